// *** pkg/dbc_defines.svh ***
`ifndef DBC_DEFINES_SVH
`define DBC_DEFINES_SVH

// Converter word and the low group rewritten by the second byte
`define DBC_CODE_W 10
`define DBC_LOW_W 2
`define DBC_BUS_W 16
`define DBC_CODE_RST 10'h000

// Write strobe and gap width, rounded up to whole clocks
`define DBC_CLK_NS 20
`define DBC_WR_NS 100
`define DBC_WR_CYC ((`DBC_WR_NS + `DBC_CLK_NS - 1) / `DBC_CLK_NS)

// Controller register offsets (byte addresses)
`define DBC_OFS_CTRL 12'h000
`define DBC_OFS_DATA 12'h004
`define DBC_OFS_LATCH_TRANSFER_STROBE 12'h008
`define DBC_OFS_STAT 12'h00C

// Transfer mode codes held in the control register
`define DBC_MODE_AUTO8 3'h0
`define DBC_MODE_PROC8 3'h1
`define DBC_MODE_EXT8 3'h2
`define DBC_MODE_SNGL16 3'h3
`define DBC_MODE_DBL16 3'h4
`define DBC_MODE_FLOW 3'h5
`define DBC_MODE_RST 3'h0

// Status fields
`define DBC_STAT_BUSY 0
`define DBC_STAT_PEND 1

// AXI responses
`define DBC_RESP_OKAY 2'h0
`define DBC_RESP_SLVERR 2'h2

`endif

// *** pkg/dbc_pkg.sv ***
package dbc_pkg;

  // Controller sequencing states
  typedef enum logic [2:0] {
    HS_IDLE, HS_FIRST, HS_GAP, HS_SECOND, HS_LATCH_TRANSFER_STROBE, HS_REST, HS_FLOW
  } dbc_hstate_e;

  // Converter end state
  typedef struct packed {
    logic [9:0] inLatch;
    logic [9:0] dacLatch;
    logic awaitLow;
    logic xferPulse;
    logic xferSeen;
  } dbc_dev_s;

  // Controller end state
  typedef struct packed {
    dbc_hstate_e state;
    logic [7:0] cnt;
    logic [2:0] mode;
    logic [9:0] code;
    logic pend;
    logic awHave;
    logic [11:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awReady;
    logic wReady;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic csN;
    logic wrN;
    logic byteSelect;
    logic xferN;
    logic [15:0] bus;
  } dbc_hst_s;

endpackage

// *** pkg/dbc_link_if.sv ***
`timescale 1ns/1ns
// Parallel write port between controller and converter; all one-way
interface dbc_link_if;
  logic [15:0] dataBus;
  logic csN;
  logic wrN;
  logic byteSelect;
  logic latchTransferStrobeN;

  modport host (
    output dataBus,
    output csN,
    output wrN,
    output byteSelect,
    output latchTransferStrobeN
  );

  modport dev (
    input dataBus,
    input csN,
    input wrN,
    input byteSelect,
    input latchTransferStrobeN
  );
endinterface

// *** rtl/dbc_converter.sv ***
`timescale 1ns/1ns
`include "dbc_defines.svh"
// How it works
// RQ1: 8-bit bus: code arrives as two writes
// RQ2: First write loads all ten latch bits
// RQ3: Second write rewrites only the low pair
// RQ4: Host sends high byte first, left-justified
// RQ5: Input latch feeds output latch by transfer
// RQ6: Automatic mode: second byte also transfers
// RQ7: Host strobe may update many converters together
// RQ8: External logic may supply the transfer strobe
// RQ9: 16-bit bus single-buffered loading supported
// RQ10: 16-bit bus double-buffered common transfer supported
// RQ11: Stand-alone double buffering uses both stages
// RQ12: Flow-through: both latches transparent
// RQ13: Host places code in word, rest ignored
// RQ14: Second-byte select strobes low pair, transfers
// RQ15: Processor transfer strobe rides a third write
// RQ16: 16-bit bus ties byte select high
// RQ17: Output latch follows strobe, holds after
// RQ18: Output latch drives ladder code continuously
//
// The two latches are level-sensitive in the original part. Here each
// one is a register that reloads on every clock while its enable is
// active, so "transparent" means the output follows with one clock of
// delay, and the last value stays once the enable drops.
module dbc_converter #(
  parameter bit BUS16 = 1'b0
) (
  dbc_link_if.dev link,
  input wire logic clk_sys,
  input wire logic resetn,
  output logic [`DBC_CODE_W-1:0] dacCode,
  output logic [`DBC_CODE_W-1:0] heldCode,
  output logic awaitingLow,
  output logic transferDone
);

  localparam int CODE_W = `DBC_CODE_W;
  localparam int LOW_W = `DBC_LOW_W;

  // The state struct is laid out for exactly this word split
  generate
    if (CODE_W != 10 || LOW_W != 2) begin : g_bad_split
      $error("dbc_converter: word split must be 10 bits over 8 plus 2");
    end
  endgenerate

  dbc_pkg::dbc_dev_s state_r;
  dbc_pkg::dbc_dev_s state_nxt;

  logic [CODE_W-1:0] pinWord;
  logic [CODE_W-1:0] bitEn;
  logic [CODE_W-1:0] latchNext;
  logic inputEn;
  logic xferEn;

  // Bus wiring chosen by strapping. On the narrow bus the ten latch
  // inputs hang on eight lines: the top eight take the whole byte and
  // the low pair shares the top two lines of that byte, which is where
  // a left-justified low group lands on the second write.
  generate
    if (BUS16) begin : g_wide
      // Code sits in the upper ten lines; the six below are ignored
      assign pinWord = link.dataBus[15:6]; // [RQ13] [RQ9] [RQ10]
    end else begin : g_narrow
      // High byte fills bits 9..2, low pair read from lines 7..6
      assign pinWord = {link.dataBus[7:0], link.dataBus[7:6]}; // [RQ1] [RQ4]
    end
  endgenerate

  // Chip select and write together open the input latch. The transfer
  // path does not look at chip select, so several converters sharing
  // one write and one strobe all update on the same clock.
  assign inputEn = !link.csN && !link.wrN;
  assign xferEn = !link.latchTransferStrobeN && !link.wrN; // [RQ7] [RQ8]

  // Per-bit enable of the input latch. With byte select high every bit
  // loads (first byte, or the single wide write); with it low only the
  // low pair opens and the eight upper bits keep what they caught.
  genvar i;
  generate
    for (i = 0; i < CODE_W; i = i + 1) begin : g_bit
      if (i < LOW_W) begin : g_low
        // Low pair opens on either byte
        assign bitEn[i] = inputEn; // [RQ2] [RQ14]
      end else begin : g_high
        // Upper bits open only while byte select is high
        assign bitEn[i] = inputEn && link.byteSelect; // [RQ2] [RQ3] [RQ16]
      end
      // Each bit either follows its pin or holds
      assign latchNext[i] = bitEn[i] ? pinWord[i] : state_r.inLatch[i];
    end
  endgenerate

  // Next state of both stages
  always_comb begin
    state_nxt = state_r;
    state_nxt.xferPulse = 1'b0;
    state_nxt.xferSeen = xferEn; // Strobe history for the end report

    // Input latch: first stage of the cascade
    state_nxt.inLatch = latchNext; // [RQ2] [RQ3]

    // Track whether a high byte is waiting for its low pair. This is
    // only a status hint: the latch itself never refuses a write.
    if (inputEn && link.byteSelect && !BUS16) begin
      state_nxt.awaitLow = 1'b1; // [RQ1]
    end else if (inputEn && !link.byteSelect) begin
      state_nxt.awaitLow = 1'b0; // [RQ1]
    end

    // Output latch takes only the input latch's word, and takes its
    // next value so that a second byte and a transfer on the same write
    // move the complete new word at once. Flow-through is this same
    // path with select, write and strobe all held active.
    if (xferEn) begin
      state_nxt.dacLatch = latchNext; // [RQ5] [RQ6] [RQ12] [RQ17]
    end

    // Report the end of a transfer window once, one clock after the strobe is released
    if (state_r.xferPulse == 1'b0 && !xferEn && state_r.xferSeen) begin
      state_nxt.xferPulse = 1'b1; // [RQ11]
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_r <= '{
        inLatch: `DBC_CODE_RST,
        dacLatch: `DBC_CODE_RST,
        awaitLow: 1'b0,
        xferPulse: 1'b0,
        xferSeen: 1'b0
      };
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from the state register; the ladder code is
  // present at all times, not only around a transfer
  assign dacCode = state_r.dacLatch; // [RQ18]
  assign heldCode = state_r.inLatch; // [RQ5]
  assign awaitingLow = state_r.awaitLow;
  assign transferDone = state_r.xferPulse; // [RQ10] [RQ11]

endmodule

// *** rtl/dbc_controller.sv ***
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ns
`include "dbc_defines.svh"
// Bus-side controller: takes a code and a mode from software over
// AXI4-Lite and plays the write sequence on the converter's pins.
module dbc_controller (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic extStrobeN,
  dbc_link_if.host link
);

  localparam logic [7:0] WR_LAST = 8'(`DBC_WR_CYC - 1);

  dbc_pkg::dbc_hst_s s_r;
  dbc_pkg::dbc_hst_s s_nxt;

  logic isWide;
  logic autoXfer;

  // Mode decode for the current setting
  always_comb begin
    isWide = (s_r.mode == `DBC_MODE_SNGL16) ||
             (s_r.mode == `DBC_MODE_DBL16);
    autoXfer = (s_r.mode == `DBC_MODE_AUTO8) ||
               (s_r.mode == `DBC_MODE_SNGL16);
  end

  // Bus slave, register effects and pin sequencer
  always_comb begin
    s_nxt = s_r;
    // Responses retire when taken
    if (s_r.bValid && bready) begin
      s_nxt.bValid = 1'b0;
    end
    if (s_r.rValid && rready) begin
      s_nxt.rValid = 1'b0;
    end
    // Address and data are caught independently, in either order
    if (awvalid && s_r.awReady) begin
      s_nxt.awHave = 1'b1;
      s_nxt.awAddr = awaddr;
    end
    if (wvalid && s_r.wReady) begin
      s_nxt.wHave = 1'b1;
      s_nxt.wData = wdata;
      s_nxt.wStrb = wstrb;
    end
    // Write takes effect once both halves are in; a write while the
    // pins are busy is answered but changes nothing, so a sequence is
    // never torn halfway
    if (s_nxt.awHave && s_nxt.wHave && !s_nxt.bValid) begin
      s_nxt.awHave = 1'b0;
      s_nxt.wHave = 1'b0;
      s_nxt.bValid = 1'b1;
      s_nxt.bResp = `DBC_RESP_OKAY;
      unique case (s_nxt.awAddr)
        `DBC_OFS_CTRL: begin
          // Codes above flow-through name no mode; the old one stays
          if (s_nxt.wStrb[0] && s_r.state == dbc_pkg::HS_IDLE &&
              s_nxt.wData[2:0] <= `DBC_MODE_FLOW) begin
            s_nxt.mode = s_nxt.wData[2:0];
          end
        end
        `DBC_OFS_DATA: begin
          // Code is frozen while a sequence plays, except when streaming
          if (s_r.state == dbc_pkg::HS_IDLE ||
              s_r.state == dbc_pkg::HS_FLOW) begin
            if (s_nxt.wStrb[0]) begin
              s_nxt.code[7:0] = s_nxt.wData[7:0];
            end
            if (s_nxt.wStrb[1]) begin
              s_nxt.code[9:8] = s_nxt.wData[9:8];
            end
          end
          if (s_r.state == dbc_pkg::HS_IDLE && s_r.mode != `DBC_MODE_FLOW) begin
            s_nxt.cnt = WR_LAST;
            s_nxt.state = isWide ? dbc_pkg::HS_SECOND : dbc_pkg::HS_FIRST;
          end
        end
        `DBC_OFS_LATCH_TRANSFER_STROBE: begin
          // Third write carrying the shared transfer strobe
          if (s_r.state == dbc_pkg::HS_IDLE && s_r.mode != `DBC_MODE_FLOW) begin
            s_nxt.cnt = WR_LAST;
            s_nxt.state = dbc_pkg::HS_LATCH_TRANSFER_STROBE; // [RQ15] [RQ7]
          end
        end
        `DBC_OFS_STAT: begin
        end
        default: begin
          s_nxt.bResp = `DBC_RESP_SLVERR;
        end
      endcase
    end
    s_nxt.awReady = !s_nxt.awHave && !s_nxt.bValid;
    s_nxt.wReady = !s_nxt.wHave && !s_nxt.bValid;
    // Read: one outstanding, answered the clock after the address
    if (arvalid && s_r.arReady) begin
      s_nxt.rValid = 1'b1;
      s_nxt.rResp = `DBC_RESP_OKAY;
      s_nxt.rData = 32'h0000_0000;
      unique case (araddr)
        `DBC_OFS_CTRL: s_nxt.rData[2:0] = s_r.mode;
        `DBC_OFS_DATA: s_nxt.rData[9:0] = s_r.code;
        `DBC_OFS_LATCH_TRANSFER_STROBE: begin
        end
        `DBC_OFS_STAT: begin
          s_nxt.rData[`DBC_STAT_BUSY] = (s_r.state != dbc_pkg::HS_IDLE) &&
                                        (s_r.state != dbc_pkg::HS_FLOW);
          s_nxt.rData[`DBC_STAT_PEND] = s_r.pend;
        end
        default: s_nxt.rResp = `DBC_RESP_SLVERR;
      endcase
    end
    s_nxt.arReady = !s_nxt.rValid;

    // Control pins idle by default and the bus keeps its last value; each phase below drives its own levels
    s_nxt.csN = 1'b1;
    s_nxt.wrN = 1'b1;
    s_nxt.byteSelect = 1'b1;
    s_nxt.xferN = 1'b1;
    if (s_r.cnt != 8'h00) begin
      s_nxt.cnt = s_r.cnt - 8'h01;
    end
    unique case (s_r.state)
      dbc_pkg::HS_IDLE: begin
        if (s_r.mode == `DBC_MODE_FLOW) begin
          s_nxt.state = dbc_pkg::HS_FLOW;
        end
      end
      dbc_pkg::HS_FIRST: begin
        // High byte first, all ten bits open
        s_nxt.csN = 1'b0;
        s_nxt.wrN = 1'b0;
        s_nxt.bus = {8'h00, s_r.code[9:2]}; // [RQ1] [RQ4]
        if (s_r.cnt == 8'h00) begin
          s_nxt.cnt = WR_LAST;
          s_nxt.state = dbc_pkg::HS_GAP;
        end
      end
      dbc_pkg::HS_GAP: begin
        if (s_r.cnt == 8'h00) begin
          s_nxt.cnt = WR_LAST;
          s_nxt.state = dbc_pkg::HS_SECOND;
        end
      end
      dbc_pkg::HS_SECOND: begin
        // Low pair on the narrow bus, whole word on the wide one
        s_nxt.csN = 1'b0;
        s_nxt.wrN = 1'b0;
        s_nxt.byteSelect = isWide; // [RQ16]
        s_nxt.xferN = !autoXfer; // [RQ6] [RQ9]
        s_nxt.bus = isWide ? {s_r.code, 6'h00} :
                    {8'h00, s_r.code[1:0], 6'h00}; // [RQ13]
        s_nxt.pend = !autoXfer;
        if (s_r.cnt == 8'h00) begin
          s_nxt.cnt = WR_LAST;
          s_nxt.state = dbc_pkg::HS_REST;
        end
      end
      dbc_pkg::HS_LATCH_TRANSFER_STROBE: begin
        // Write with the strobe and no select reaches only the output
        s_nxt.wrN = 1'b0;
        s_nxt.xferN = 1'b0; // [RQ10]
        s_nxt.pend = 1'b0;
        if (s_r.cnt == 8'h00) begin
          s_nxt.cnt = WR_LAST;
          s_nxt.state = dbc_pkg::HS_REST;
        end
      end
      dbc_pkg::HS_REST: begin
        if (s_r.cnt == 8'h00) begin
          s_nxt.state = dbc_pkg::HS_IDLE;
        end
      end
      dbc_pkg::HS_FLOW: begin
        // Everything held open; the code register streams through
        s_nxt.csN = 1'b0;
        s_nxt.wrN = 1'b0;
        s_nxt.xferN = 1'b0; // [RQ12]
        s_nxt.bus = {s_r.code, 6'h00};
        if (s_r.mode != `DBC_MODE_FLOW) begin
          s_nxt.state = dbc_pkg::HS_IDLE;
        end
      end
    endcase
    // Independent logic owns the strobe in external mode
    if (s_r.mode == `DBC_MODE_EXT8) begin
      s_nxt.xferN = extStrobeN; // [RQ8]
      s_nxt.wrN = s_nxt.wrN && extStrobeN;
      if (!extStrobeN) begin
        s_nxt.pend = 1'b0; // [RQ8]
      end
    end
  end

  // State register; once in flow mode the mode cannot be rewritten, so only reset leaves it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
      s_r.state <= dbc_pkg::HS_IDLE;
      s_r.mode <= `DBC_MODE_RST;
      s_r.awReady <= 1'b1;
      s_r.wReady <= 1'b1;
      s_r.arReady <= 1'b1;
      s_r.csN <= 1'b1;
      s_r.wrN <= 1'b1;
      s_r.byteSelect <= 1'b1;
      s_r.xferN <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign awready = s_r.awReady;
  assign wready = s_r.wReady;
  assign bvalid = s_r.bValid;
  assign bresp = s_r.bResp;
  assign arready = s_r.arReady;
  assign rvalid = s_r.rValid;
  assign rdata = s_r.rData;
  assign rresp = s_r.rResp;
  assign link.csN = s_r.csN;
  assign link.wrN = s_r.wrN;
  assign link.byteSelect = s_r.byteSelect;
  assign link.latchTransferStrobeN = s_r.xferN;
  assign link.dataBus = s_r.bus;

endmodule

// *** bench/dbc_link_asserts.sv ***
`timescale 1ns/1ns
// Watches the converter pins and the 8-bit converter's two latches
module dbc_link_asserts (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [15:0] dataBus,
  input wire logic csN,
  input wire logic wrN,
  input wire logic byteSelect,
  input wire logic latchTransferStrobeN,
  input wire logic [9:0] dacCode,
  input wire logic [9:0] heldCode,
  input wire logic awaitingLow,
  input wire logic transferDone
);
  default clocking dbc_cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // Remembers whether the last chip-select window carried the high byte
  logic firstLoaded_r;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      firstLoaded_r <= 1'b0;
    end else if (!csN) begin
      firstLoaded_r <= byteSelect;
    end
  end

  property p_first;
    (!csN && !wrN && byteSelect) |=> heldCode[9:2] == $past(dataBus[7:0])
      && heldCode[1:0] == $past(dataBus[7:6]);
  endproperty
  a_first: assert property (p_first)
    else $error("first byte not loaded into all ten bits");

  property p_second;
    (!csN && !wrN && !byteSelect) |=> heldCode[1:0] == $past(dataBus[7:6])
      && $stable(heldCode[9:2]);
  endproperty
  a_second: assert property (p_second)
    else $error("second byte touched more than the low pair");

  property p_latch_transfer_strobe;
    (!wrN && !latchTransferStrobeN) |=> dacCode == heldCode;
  endproperty
  a_latch_transfer_strobe: assert property (p_latch_transfer_strobe)
    else $error("output latch missed the transfer");

  property p_hold_out;
    (wrN || latchTransferStrobeN) |=> $stable(dacCode);
  endproperty
  a_hold_out: assert property (p_hold_out)
    else $error("output latch changed without a transfer");

  property p_hold_in;
    (csN || wrN) |=> $stable(heldCode);
  endproperty
  a_hold_in: assert property (p_hold_in)
    else $error("input latch changed without a write");

  // Write strobes and the gaps between them last the full write time
  property p_cs_width;
    $fell(csN) |-> (!csN) [*5];
  endproperty
  a_cs_width: assert property (p_cs_width)
    else $error("chip select window shorter than a write");

  property p_cs_gap;
    $rose(csN) |-> csN [*5];
  endproperty
  a_cs_gap: assert property (p_cs_gap)
    else $error("gap between writes too short");

  property p_order;
    ($fell(csN) && !byteSelect) |-> firstLoaded_r;
  endproperty
  a_order: assert property (p_order)
    else $error("low pair written without a high byte first");

  // High-byte status follows the select of the last write
  property p_await;
    (!csN && !wrN) |=> awaitingLow == $past(byteSelect);
  endproperty
  a_await: assert property (p_await)
    else $error("high-byte status does not follow the last write");

  // One report the clock after a transfer window closes
  property p_done;
    (!wrN && !latchTransferStrobeN) ##1 (wrN || latchTransferStrobeN)
      |=> transferDone;
  endproperty
  a_done: assert property (p_done)
    else $error("end of transfer not reported");
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/1ns
`include "dbc_defines.svh"
module testbench;
  typedef struct {
    logic [2:0] mode;
    logic [9:0] code;
    bit wide;
    bit latch_transfer_strobe;
  } dbc_row_s;
  logic clk_sys;
  logic resetn;
  logic [11:0] awaddr;
  logic [11:0] araddr;
  logic awvalid;
  logic wvalid;
  logic bready;
  logic arvalid;
  logic rready;
  logic extStrobeN;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awready;
  logic wready;
  logic bvalid;
  logic arready;
  logic rvalid;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [31:0] rdata;
  logic [9:0] dac8;
  logic [9:0] held8;
  logic [9:0] dac16;
  logic awaitingLow;
  logic transferDone;
  logic [31:0] rd;
  logic [1:0] resp;
  logic [9:0] lastCode;
  int error_cnt;
  int samples_checked;
  dbc_row_s rows[7];

  dbc_link_if link();
  dbc_controller dbc_controller_i (.clk_sys(clk_sys), .resetn(resetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .extStrobeN(extStrobeN), .link(link));
  // Two converters share one link: 8-bit and 16-bit wiring
  dbc_converter #(.BUS16(1'b0)) dbc_converter_i (.link(link),
    .clk_sys(clk_sys), .resetn(resetn), .dacCode(dac8), .heldCode(held8),
    .awaitingLow(awaitingLow), .transferDone(transferDone));
  dbc_converter #(.BUS16(1'b1)) dbc_converter16_i (.link(link),
    .clk_sys(clk_sys), .resetn(resetn), .dacCode(dac16), .heldCode(),
    .awaitingLow(), .transferDone());
  dbc_link_asserts dbc_link_asserts_i (.clk_sys(clk_sys), .resetn(resetn),
    .dataBus(link.dataBus), .csN(link.csN), .wrN(link.wrN),
    .byteSelect(link.byteSelect),
    .latchTransferStrobeN(link.latchTransferStrobeN), .dacCode(dac8),
    .heldCode(held8), .awaitingLow(awaitingLow),
    .transferDone(transferDone));

  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic timeout(input string name);
    error_cnt++;
    $display("MISMATCH %s expected answer seen timeout", name);
    stop_test();
  endtask

  // Address and data offered together; bready held until bvalid seen
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int i;
    @(posedge clk_sys);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (i == 50) timeout("bvalid");
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int i;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (i == 50) timeout("rvalid");
  endtask

  // Busy is already up when the write response returns; polling still starts three edges late
  task automatic wait_idle();
    int i;
    repeat (3) @(posedge clk_sys);
    for (i = 0; i < 100; i++) begin
      axi_rd(`DBC_OFS_STAT, rd, resp);
      if (rd[0] === 1'b0) break;
    end
    if (i == 100) timeout("idle");
  endtask

  task automatic wait_dac16(input logic [9:0] c);
    int i;
    for (i = 0; i < 40 && dac16 !== c; i++) @(posedge clk_sys);
    check("flow", dac16, c);
  endtask

  // Main sequence: reset, awkward cases, table rows, then flow-through
  initial begin
    resetn = 1'b0;
    {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    extStrobeN = 1'b1;
    rows = '{'{`DBC_MODE_AUTO8, 10'h3FF, 0, 0},
      '{`DBC_MODE_AUTO8, 10'h000, 0, 0}, '{`DBC_MODE_PROC8, 10'h2AA, 0, 1},
      '{`DBC_MODE_AUTO8, 10'h155, 0, 0}, '{`DBC_MODE_SNGL16, 10'h3FE, 1, 0},
      '{`DBC_MODE_DBL16, 10'h201, 1, 1}, '{`DBC_MODE_SNGL16, 10'h001, 1, 0}};
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    check("dacRst", dac8, 10'h000);
    check("heldRst", held8, 10'h000);
    axi_rd(`DBC_OFS_STAT, rd, resp);
    check("statRst", rd, 32'h0000_0000);
    $display("reset test done");
    axi_wr(12'h010, 32'h0000_0001, resp);
    check("wrResp", resp, `DBC_RESP_SLVERR);
    axi_rd(12'h010, rd, resp);
    check("rdResp", resp, `DBC_RESP_SLVERR);
    axi_wr(`DBC_OFS_CTRL, 32'h0000_0007, resp);
    axi_rd(`DBC_OFS_CTRL, rd, resp);
    check("badMode", rd[2:0], `DBC_MODE_AUTO8);
    $display("refusal test done");
    // Second code arrives while the first is still being written
    axi_wr(`DBC_OFS_DATA, 32'h0000_00F0, resp);
    axi_wr(`DBC_OFS_DATA, 32'h0000_030C, resp);
    wait_idle();
    check("dacB2b", dac8, 10'h0F0);
    check("heldB2b", held8, 10'h0F0);
    $display("back-to-back test done");
    // Transfer waits for the independent strobe
    axi_wr(`DBC_OFS_CTRL, {29'h0, `DBC_MODE_EXT8}, resp);
    axi_wr(`DBC_OFS_DATA, 32'h0000_02C5, resp);
    wait_idle();
    check("heldExt", held8, 10'h2C5);
    check("dacExtHold", dac8, 10'h0F0);
    check("pendExt", rd[1], 1'b1);
    @(posedge clk_sys);
    extStrobeN <= 1'b0;
    repeat (6) @(posedge clk_sys);
    extStrobeN <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check("dacExt", dac8, 10'h2C5);
    axi_rd(`DBC_OFS_STAT, rd, resp);
    check("pendExtClr", rd[1], 1'b0);
    $display("external strobe test done");
    lastCode = 10'h2C5;
    foreach (rows[k]) begin
      axi_wr(`DBC_OFS_CTRL, {29'h0, rows[k].mode}, resp);
      axi_rd(`DBC_OFS_CTRL, rd, resp);
      check("mode", rd[2:0], rows[k].mode);
      axi_wr(`DBC_OFS_DATA, {22'h0, rows[k].code}, resp);
      wait_idle();
      if (rows[k].latch_transfer_strobe) begin
        check("pend", rd[1], 1'b1);
        check("dacHold", rows[k].wide ? dac16 : dac8, lastCode);
        axi_wr(`DBC_OFS_LATCH_TRANSFER_STROBE, 32'h0000_0000, resp);
        wait_idle();
        check("pendClr", rd[1], 1'b0);
      end
      if (!rows[k].wide) check("held", held8, rows[k].code);
      check("dac", rows[k].wide ? dac16 : dac8, rows[k].code);
      lastCode = rows[k].code;
      $display("row %0d done", k);
    end
    // Reset in mid-run clears the output latch of both converters
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check("dacMid", dac8, 10'h000);
    check("dac16Mid", dac16, 10'h000);
    resetn <= 1'b1;
    $display("mid-run reset test done");
    axi_wr(`DBC_OFS_CTRL, {29'h0, `DBC_MODE_FLOW}, resp);
    axi_wr(`DBC_OFS_DATA, 32'h0000_011A, resp);
    wait_dac16(10'h11A);
    axi_wr(`DBC_OFS_DATA, 32'h0000_03A5, resp);
    wait_dac16(10'h3A5);
    $display("flow-through test done");
    stop_test();
  end
endmodule
